// ### vbsfsc_pkg.sv
package vbsfsc_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'hc6;
    localparam logic [7:0] ADDR_WCOUNT = 8'hc7;
    localparam logic [7:0] ADDR_THRESH = 8'hc8;
    localparam logic [7:0] ADDR_FLUSH = 8'hc9;
    localparam logic [7:0] ADDR_LINEIRQ = 8'hca;
    localparam logic [7:0] ADDR_SWLO = 8'hcb;
    localparam logic [7:0] ADDR_SWHI = 8'hcc;
    localparam logic [7:0] ADDR_ROUTE = 8'hcd;
    localparam logic [7:0] ADDR_CLKSTD = 8'hce;
    localparam logic [7:0] ADDR_FFEN = 8'hcf;
    localparam logic [7:0] ADDR_FFMODE = 8'hfc;
    localparam logic [7:0] ADDR_FIFODATA = 8'hc0;
    localparam logic [7:0] RST_THRESH = 8'h80;
    localparam logic [7:0] RST_LINEIRQ = 8'h00;
    localparam logic [9:0] RST_SWITCH = 10'h359;
    localparam logic RST_ROUTE = 1'b1;
    localparam logic RST_CLKSTD = 1'b0;
    localparam logic RST_FFEN = 1'b0;
    localparam logic [7:0] RST_FFMODE = 8'h7f;
    localparam logic [7:0] LINE_MODE_FULL = 8'hff;
    localparam logic [5:0] LINE_MIN_IRQ = 6'h02;
    localparam int BIT_FULL_ERR = 7;
    localparam int BIT_EMPTY = 6;
    localparam int BIT_F1EN = 7;
    localparam int BIT_F2EN = 6;
    typedef struct packed {
        logic teletext_flag;
        logic caption_flag_f1;
        logic caption_flag_f2;
        logic widescreen_signal_flag;
        logic programme_delivery_flag;
        logic vertical_timecode_flag;
    } vbsfsc_avail_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } vbsfsc_bus_s;
endpackage

// ### vbsfsc_top.sv
`timescale 1ns/1ps
module vbsfsc_top
    import vbsfsc_pkg::*;
#(
    parameter int DEPTH_WORDS = 255
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic line_push,
    input wire logic [7:0] line_words,
    input wire vbsfsc_avail_s line_kind,
    input wire logic word_valid,
    input wire logic [15:0] word_data,
    input wire vbsfsc_avail_s reg_avail,
    input wire logic [5:0] video_line,
    input wire logic line_start,
    input wire logic field_two,
    input wire logic in_vblank,
    input wire logic [7:0] line_mode,
    input wire logic [9:0] pixel_pos,
    input wire logic [1:0] irq_enable,
    output logic thresh_cond,
    output logic line_cond,
    output logic irq_out,
    output logic load_standard,
    output logic slice_en,
    output logic [7:0] slice_mode,
    output logic clock_std,
    output logic [7:0] video_y_out,
    output logic video_y_valid
);
    // ==========================================================
    // Checks
    // Pointers and the count are eight bits wide, so a deeper FIFO would wrap silently.
    if (DEPTH_WORDS < 2 || DEPTH_WORDS > 255) begin : g_depth_bad
        $error("DEPTH_WORDS must be 2..255");
    end

    localparam logic [7:0] DEPTH_W = 8'(DEPTH_WORDS);

    // ==========================================================
    // State
    typedef struct packed {
        vbsfsc_avail_s avail;
        logic full_err;
        logic [7:0] count;
        logic [7:0] wptr;
        logic [7:0] rptr;
        logic [7:0] room;
        logic [7:0] thresh;
        logic [7:0] lineirq;
        logic [9:0] sw_pos;
        logic route;
        logic clkstd;
        logic ffen;
        logic [7:0] ffmode;
        logic byte_hi;
        logic [7:0] rdata;
        logic thresh_c;
        logic line_c;
        logic irq;
        logic load;
        logic slen;
        logic [7:0] smode;
        logic [7:0] ydata;
        logic yvalid;
    } vbsfsc_state_s;

    vbsfsc_state_s st_reg;
    vbsfsc_state_s st_next;
    logic [15:0] mem [0:255];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    logic fifo_take;
    logic fifo_pop;
    logic do_push;
    logic line_fits;
    logic [7:0] line_room;
    assign line_room = DEPTH_W - st_reg.count;
    // The header word needs room too; nine bits keep a 255 word line from wrapping to zero.
    assign line_fits = ({1'b0, line_words} + 9'h001) <= {1'b0, line_room};
    assign do_push = word_valid && (st_reg.room != 8'h00);
    // Each word leaves as two bytes, high byte first, and is popped with its low byte.
    assign fifo_take = (st_reg.count != 8'h00) && ((bus_rd && hit(bus_addr, ADDR_FIFODATA)
        && st_reg.route) || (!st_reg.route));
    assign fifo_pop = fifo_take && st_reg.byte_hi;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[st_reg.wptr] <= word_data;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic flush;
        logic [7:0] cnt;
        logic [15:0] head;
        flush = 1'b0;
        cnt = st_reg.count;
        head = mem[st_reg.rptr];
        st_next = st_reg;
        st_next.load = 1'b0;
        st_next.yvalid = 1'b0;
        st_next.avail = st_reg.avail | reg_avail;
        if (bus_wr) begin
            if (hit(bus_addr, ADDR_STATUS)) begin
                st_next.avail = (st_reg.avail & ~vbsfsc_avail_s'(bus_wdata[5:0])) | reg_avail;
                st_next.full_err = st_reg.full_err & ~bus_wdata[BIT_FULL_ERR];
            end
            if (hit(bus_addr, ADDR_THRESH)) st_next.thresh = bus_wdata;
            if (hit(bus_addr, ADDR_FLUSH)) flush = 1'b1;
            if (hit(bus_addr, ADDR_LINEIRQ)) st_next.lineirq = bus_wdata;
            if (hit(bus_addr, ADDR_SWLO)) st_next.sw_pos[7:0] = bus_wdata;
            if (hit(bus_addr, ADDR_SWHI)) st_next.sw_pos[9:8] = bus_wdata[1:0];
            if (hit(bus_addr, ADDR_ROUTE)) st_next.route = bus_wdata[0];
            if (hit(bus_addr, ADDR_CLKSTD)) st_next.clkstd = bus_wdata[0];
            if (hit(bus_addr, ADDR_FFEN)) st_next.ffen = bus_wdata[0];
            if (hit(bus_addr, ADDR_FFMODE)) st_next.ffmode = bus_wdata;
        end
        if (line_push) begin
            if (!line_fits) begin
                st_next.full_err = 1'b1;
                st_next.room = 8'h00;
            end else begin
                st_next.room = line_words + 8'h01;
                st_next.avail = st_next.avail | line_kind;
            end
        end else if (do_push) begin
            st_next.room = st_reg.room - 8'h01;
        end
        if (do_push) begin
            st_next.wptr = (st_reg.wptr == DEPTH_W - 8'h01) ? 8'h00 : st_reg.wptr + 8'h01;
        end
        if (fifo_pop) begin
            st_next.rptr = (st_reg.rptr == DEPTH_W - 8'h01) ? 8'h00 : st_reg.rptr + 8'h01;
        end
        if (fifo_take) begin
            st_next.byte_hi = ~st_reg.byte_hi;
        end
        cnt = st_reg.count + (do_push ? 8'h01 : 8'h00) - (fifo_pop ? 8'h01 : 8'h00);
        st_next.count = cnt;
        if (flush) begin
            st_next.count = 8'h00;
            st_next.wptr = 8'h00;
            st_next.rptr = 8'h00;
            st_next.room = 8'h00;
            st_next.byte_hi = 1'b0;
            cnt = 8'h00;
        end
        if (!st_reg.route && fifo_take) begin
            st_next.ydata = st_reg.byte_hi ? head[7:0] : head[15:8];
            st_next.yvalid = 1'b1;
        end
        st_next.thresh_c = cnt > st_next.thresh;
        st_next.line_c = line_start && (video_line == st_reg.lineirq[5:0])
            && (st_reg.lineirq[5:0] >= LINE_MIN_IRQ)
            && (field_two ? st_reg.lineirq[BIT_F2EN] : st_reg.lineirq[BIT_F1EN]);
        st_next.irq = (st_next.thresh_c && irq_enable[1]) || (st_next.line_c && irq_enable[0]);
        if (pixel_pos == st_reg.sw_pos) begin
            st_next.load = 1'b1;
            // line override
            // Line modes only cover blanking lines, so active video always takes the full field.
            if (!in_vblank || line_mode == LINE_MODE_FULL) begin
                st_next.slen = st_reg.ffen;
                st_next.smode = st_reg.ffmode;
            end else begin
                st_next.slen = 1'b1;
                st_next.smode = line_mode;
            end
        end
        st_next.rdata = 8'h00;
        if (bus_rd) begin
            if (hit(bus_addr, ADDR_STATUS)) begin
                st_next.rdata = {st_reg.full_err, st_reg.count == 8'h00, st_reg.avail};
            end
            if (hit(bus_addr, ADDR_WCOUNT)) st_next.rdata = st_reg.count;
            if (hit(bus_addr, ADDR_THRESH)) st_next.rdata = st_reg.thresh;
            if (hit(bus_addr, ADDR_LINEIRQ)) st_next.rdata = st_reg.lineirq;
            if (hit(bus_addr, ADDR_SWLO)) st_next.rdata = st_reg.sw_pos[7:0];
            if (hit(bus_addr, ADDR_SWHI)) st_next.rdata = {6'h00, st_reg.sw_pos[9:8]};
            if (hit(bus_addr, ADDR_ROUTE)) st_next.rdata = {7'h00, st_reg.route};
            if (hit(bus_addr, ADDR_CLKSTD)) st_next.rdata = {7'h00, st_reg.clkstd};
            if (hit(bus_addr, ADDR_FFEN)) st_next.rdata = {7'h00, st_reg.ffen};
            if (hit(bus_addr, ADDR_FFMODE)) st_next.rdata = st_reg.ffmode;
            if (hit(bus_addr, ADDR_FIFODATA) && st_reg.route && st_reg.count != 8'h00) begin
                st_next.rdata = st_reg.byte_hi ? head[7:0] : head[15:8];
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.thresh <= RST_THRESH;
            st_reg.lineirq <= RST_LINEIRQ;
            st_reg.sw_pos <= RST_SWITCH;
            st_reg.route <= RST_ROUTE;
            st_reg.clkstd <= RST_CLKSTD;
            st_reg.ffen <= RST_FFEN;
            st_reg.ffmode <= RST_FFMODE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;
    assign thresh_cond = st_reg.thresh_c;
    assign line_cond = st_reg.line_c;
    assign irq_out = st_reg.irq;
    assign load_standard = st_reg.load;
    assign slice_en = st_reg.slen;
    assign slice_mode = st_reg.smode;
    assign clock_std = st_reg.clkstd;
    assign video_y_out = st_reg.ydata;
    assign video_y_valid = st_reg.yvalid;

    // ==========================================================
    // Assertions
    sequence s_line_refused;
        line_push && !line_fits;
    endsequence
    sequence s_line_taken;
        line_push && line_fits && !(bus_wr && bus_addr == ADDR_FLUSH);
    endsequence
    sequence s_switch_hit;
        pixel_pos == st_reg.sw_pos;
    endsequence
    sequence s_first_byte_read;
        bus_rd && !bus_wr && bus_addr == ADDR_FIFODATA && st_reg.route && !st_reg.byte_hi
            && st_reg.count != 8'h00 && !word_valid;
    endsequence
    sequence s_line_hit;
        line_start && video_line == st_reg.lineirq[5:0] && st_reg.lineirq[5:0] >= LINE_MIN_IRQ
            && (field_two ? st_reg.lineirq[BIT_F2EN] : st_reg.lineirq[BIT_F1EN]);
    endsequence

    AST_EMPTY: assert property (@(posedge clk) disable iff (rst)
        bus_rd && bus_addr == ADDR_STATUS |=> bus_rdata[BIT_EMPTY] == ($past(st_reg.count) == 0))
        else $error("empty bit wrong");
    AST_FLUSH: assert property (@(posedge clk) disable iff (rst)
        bus_wr && bus_addr == ADDR_FLUSH |=> st_reg.count == 8'h00)
        else $error("flush failed");
    AST_STICKY: assert property (@(posedge clk) disable iff (rst)
        st_reg.avail.teletext_flag && !(bus_wr && bus_addr == ADDR_STATUS && bus_wdata[5])
        |=> st_reg.avail.teletext_flag)
        else $error("flag lost");
    AST_FULLERR: assert property (@(posedge clk) disable iff (rst)
        s_line_refused |=> st_reg.full_err && st_reg.room == 8'h00)
        else $error("full error missing");
    AST_FITS: assert property (@(posedge clk) disable iff (rst)
        s_line_taken |=> st_reg.room == $past(line_words) + 8'h01)
        else $error("fitting line not taken");
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
        s_line_taken |=> (st_reg.avail & $past(line_kind)) == $past(line_kind))
        else $error("line flag not set");
    AST_THRESH: assert property (@(posedge clk) disable iff (rst)
        thresh_cond == (st_reg.count > st_reg.thresh))
        else $error("threshold mismatch");
    AST_LINE01: assert property (@(posedge clk) disable iff (rst)
        st_reg.lineirq[5:0] < 6'h02 && $stable(st_reg.lineirq) |-> !line_cond)
        else $error("line 0/1 matched");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        irq_out |-> (thresh_cond || line_cond))
        else $error("irq without cause");
    AST_ROUTE: assert property (@(posedge clk) disable iff (rst)
        video_y_valid |-> $past(!st_reg.route))
        else $error("video out while host route");
    AST_VIDEO_HOLD: assert property (@(posedge clk) disable iff (rst)
        st_reg.route |=> !video_y_valid)
        else $error("video strobe in host route");
    AST_SWITCH_LOAD: assert property (@(posedge clk) disable iff (rst)
        s_switch_hit |=> load_standard)
        else $error("no load at switch position");
    AST_SWITCH_IDLE: assert property (@(posedge clk) disable iff (rst)
        pixel_pos != st_reg.sw_pos |=> !load_standard)
        else $error("load away from switch position");
    AST_FULL_FIELD: assert property (@(posedge clk) disable iff (rst)
        s_switch_hit ##0 (!in_vblank || line_mode == LINE_MODE_FULL)
        |=> slice_en == $past(st_reg.ffen) && slice_mode == $past(st_reg.ffmode))
        else $error("full field not applied");
    AST_LINE_OWN: assert property (@(posedge clk) disable iff (rst)
        s_switch_hit ##0 (in_vblank && line_mode != LINE_MODE_FULL)
        |=> slice_en && slice_mode == $past(line_mode))
        else $error("line mode not applied");
    AST_HALF_WORD: assert property (@(posedge clk) disable iff (rst)
        s_first_byte_read |=> st_reg.byte_hi && st_reg.count == $past(st_reg.count))
        else $error("word popped after one byte");
    AST_COUNT_LIMIT: assert property (@(posedge clk) disable iff (rst)
        st_reg.count <= DEPTH_W)
        else $error("count beyond depth");
    AST_LINE_MATCH: assert property (@(posedge clk) disable iff (rst)
        s_line_hit |=> line_cond)
        else $error("line match missed");
    AST_IRQ_MASK: assert property (@(posedge clk) disable iff (rst)
        irq_enable == 2'b00 |=> !irq_out)
        else $error("masked condition on pin");
endmodule

// ### vbsfsc_host.sv
`timescale 1ns/1ps
// ============================================================
// Host processor model on the register port.
module vbsfsc_host
    import vbsfsc_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] bus_rdata,
    output vbsfsc_bus_s bus
);
    initial begin
        bus = '0;
    end
    // Each access leaves one idle cycle, so back-to-back calls never drive a strobe twice.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = bus_rdata;
        @(posedge clk);
    endtask
endmodule

// ### vbsfsc_top_tb.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the slicer status and control bank.
module vbsfsc_top_tb;
    import vbsfsc_pkg::*;
    logic clk, rst, line_push, word_valid, line_start, field_two, in_vblank;
    logic [7:0] line_words, line_mode, bus_rdata, slice_mode, video_y_out, rv;
    logic [15:0] word_data;
    logic [5:0] video_line;
    logic [9:0] pixel_pos;
    logic [1:0] irq_enable;
    logic thresh_cond, line_cond, irq_out, load_standard, slice_en, clock_std, video_y_valid;
    vbsfsc_avail_s line_kind, reg_avail;
    vbsfsc_bus_s bus;
    int bad_count = 0;
    int n_compared = 0;
    vbsfsc_host host(.clk(clk), .bus_rdata(bus_rdata), .bus(bus));
    // A ten word FIFO makes the overflow cases short.
    vbsfsc_top #(.DEPTH_WORDS(10)) dut(.clk(clk), .rst(rst), .bus_addr(bus.addr),
        .bus_wdata(bus.wdata), .bus_wr(bus.wr), .bus_rd(bus.rd), .bus_rdata(bus_rdata),
        .line_push(line_push), .line_words(line_words), .line_kind(line_kind),
        .word_valid(word_valid), .word_data(word_data), .reg_avail(reg_avail),
        .video_line(video_line), .line_start(line_start), .field_two(field_two),
        .in_vblank(in_vblank), .line_mode(line_mode), .pixel_pos(pixel_pos),
        .irq_enable(irq_enable), .thresh_cond(thresh_cond), .line_cond(line_cond),
        .irq_out(irq_out), .load_standard(load_standard), .slice_en(slice_en),
        .slice_mode(slice_mode), .clock_std(clock_std), .video_y_out(video_y_out),
        .video_y_valid(video_y_valid));
    // ============================================================
    // Helpers.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        check(rv, exp);
    endtask
    task automatic push(input logic [7:0] n, input logic [5:0] k);
        line_push <= 1'b1;
        line_words <= n;
        line_kind <= vbsfsc_avail_s'(k);
        @(posedge clk);
        line_push <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            word_valid <= 1'b1;
            word_data <= {8'ha0 + 8'(i), 8'h50 + 8'(i)};
            @(posedge clk);
        end
        word_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic sw(input logic [9:0] p, input logic exp);
        pixel_pos <= p;
        @(posedge clk);
        pixel_pos <= 10'h000;
        @(negedge clk);
        check({7'h0, load_standard}, {7'h0, exp});
        repeat (2) @(posedge clk);
    endtask
    // ============================================================
    // Scenarios.
    task automatic t_reset;
        logic [15:0] t[11] = '{16'hc880, 16'hca00, 16'hcb59, 16'hcc03, 16'hcd01, 16'hce00,
            16'hcf00, 16'hfc7f, 16'hc640, 16'hc700, 16'h1000};
        for (int i = 0; i < 11; i++) begin
            rchk(t[i][15:8], t[i][7:0]);
        end
    endtask
    task automatic t_flags;
        for (int i = 0; i < 6; i++) begin
            reg_avail <= vbsfsc_avail_s'(6'h01 << i);
            @(posedge clk);
            reg_avail <= '0;
            @(posedge clk);
            rchk(ADDR_STATUS, 8'h40 | (8'h01 << i));
            rchk(ADDR_STATUS, 8'h40 | (8'h01 << i));
            host.wr(ADDR_STATUS, 8'h01 << i);
            rchk(ADDR_STATUS, 8'h40);
        end
    endtask
    task automatic t_fifo;
        host.wr(ADDR_THRESH, 8'h07);
        irq_enable <= 2'b10;
        push(8'd6, 6'h20);
        rchk(ADDR_WCOUNT, 8'd7);
        rchk(ADDR_STATUS, 8'h20);
        check({7'h0, thresh_cond}, 8'h00);
        push(8'd4, 6'h04);
        rchk(ADDR_WCOUNT, 8'd7);
        rchk(ADDR_STATUS, 8'ha0);
        push(8'd1, 6'h10);
        rchk(ADDR_WCOUNT, 8'd9);
        rchk(ADDR_STATUS, 8'hb0);
        check({7'h0, irq_out}, 8'h01);
        rchk(ADDR_FIFODATA, 8'ha0);
        rchk(ADDR_FIFODATA, 8'h50);
        rchk(ADDR_WCOUNT, 8'd8);
        rchk(ADDR_STATUS, 8'hb0);
        irq_enable <= 2'b00;
        repeat (2) @(posedge clk);
        check({thresh_cond, irq_out}, 8'h02);
        host.wr(ADDR_FLUSH, 8'h5a);
        rchk(ADDR_WCOUNT, 8'd0);
        rchk(ADDR_STATUS, 8'hf0);
        host.wr(ADDR_STATUS, 8'hff);
        rchk(ADDR_STATUS, 8'h40);
    endtask
    task automatic t_line;
        logic [15:0] lc[7] = '{16'h8545, 16'h8585, 16'h45c5, 16'h8506, 16'hc101, 16'hc080,
            16'hc242};
        irq_enable <= 2'b01;
        for (int i = 0; i < 7; i++) begin
            host.wr(ADDR_LINEIRQ, lc[i][15:8]);
            field_two <= lc[i][7];
            video_line <= lc[i][5:0];
            line_start <= 1'b1;
            @(posedge clk);
            line_start <= 1'b0;
            @(negedge clk);
            check({7'h0, line_cond}, {7'h0, lc[i][6]});
            check({7'h0, irq_out}, {7'h0, lc[i][6]});
            @(posedge clk);
        end
    endtask
    task automatic t_slice;
        host.wr(ADDR_CLKSTD, 8'h01);
        check({7'h0, clock_std}, 8'h01);
        host.wr(ADDR_FFEN, 8'h01);
        rchk(ADDR_FFEN, 8'h01);
        // switch set well past the line start
        host.wr(ADDR_SWLO, 8'h23);
        host.wr(ADDR_SWHI, 8'h01);
        line_mode <= 8'hff;
        sw(10'h122, 1'b0);
        sw(10'h123, 1'b1);
        check({slice_en, slice_mode[6:0]}, 8'hff);
        in_vblank <= 1'b1;
        line_mode <= 8'h37;
        sw(10'h123, 1'b1);
        check(slice_mode, 8'h37);
        in_vblank <= 1'b0;
        host.wr(ADDR_FFMODE, 8'h46);
        sw(10'h123, 1'b1);
        check({slice_en, slice_mode[6:0]}, 8'hc6);
        host.wr(ADDR_FFEN, 8'h00);
        line_mode <= 8'hff;
        sw(10'h123, 1'b1);
        check({7'h0, slice_en}, 8'h00);
    endtask
    task automatic t_route;
        host.wr(ADDR_ROUTE, 8'h00);
        fork
            push(8'd1, 6'h20);
            begin
                for (int i = 0; i < 40 && video_y_valid !== 1'b1; i++) @(negedge clk);
                check(video_y_out, 8'ha0);
                @(negedge clk);
                check(video_y_out, 8'h50);
                @(negedge clk);
                check(video_y_out, 8'ha1);
                @(negedge clk);
                check({video_y_valid, video_y_out[6:0]}, 8'hd1);
            end
        join
        @(posedge clk);
        rchk(ADDR_WCOUNT, 8'd0);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ============================================================
    // Clock, sequence and watchdog.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, line_push, word_valid, line_start, field_two, in_vblank} = 6'h20;
        {line_words, line_mode, word_data, video_line, pixel_pos, irq_enable} = '0;
        line_kind = '0;
        reg_avail = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_flags;
        t_fifo;
        t_line;
        t_slice;
        t_route;
        wrap_up;
    end
    // The whole run needs well under two thousand cycles.
    initial begin
        #200000;
        bad_count++;
        wrap_up;
    end
endmodule
